// File: hdl/fpx_pkg.sv
package fpx_pkg;
  // --------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------
  localparam int XLEN     = 32;
  localparam int GPR_NUM  = 32;
  localparam int GIDX_W   = 5;
  localparam int SPRF_W   = 10;

  // --------------------------------------------------------------------
  // operation codes
  // --------------------------------------------------------------------
  localparam logic [3:0] OP_TRAP_REG = 4'h0;
  localparam logic [3:0] OP_TRAP_IMM = 4'h1;
  localparam logic [3:0] OP_AND      = 4'h2;
  localparam logic [3:0] OP_OR       = 4'h3;
  localparam logic [3:0] OP_XOR      = 4'h4;
  localparam logic [3:0] OP_NOR      = 4'h5;
  localparam logic [3:0] OP_ROT_INS  = 4'h6;
  localparam logic [3:0] OP_ROT_MASK = 4'h7;
  localparam logic [3:0] OP_ROTR_MSK = 4'h8;
  localparam logic [3:0] OP_SHL      = 4'h9;
  localparam logic [3:0] OP_SHR      = 4'hA;
  localparam logic [3:0] OP_SHL_MQ   = 4'hB;
  localparam logic [3:0] OP_SHR_MQ   = 4'hC;
  localparam logic [3:0] OP_MFSPR    = 4'hD;
  localparam logic [3:0] OP_MTSPR    = 4'hE;
  localparam logic [3:0] OP_SPR2SPR  = 4'hF;

  // --------------------------------------------------------------------
  // special register numbers, fields, reset values
  // --------------------------------------------------------------------
  localparam logic [9:0] SPR_MQ       = 10'h000;
  localparam logic [9:0] SPR_DEC_PRIV = 10'h016;
  localparam logic [9:0] SPR_DEC_OLD  = 10'h006;
  localparam int         SPR_PRIV_BIT = 4;
  localparam int         TMASK_SLT    = 0;
  localparam int         TMASK_SGT    = 1;
  localparam int         TMASK_EQ     = 2;
  localparam int         TMASK_ULT    = 3;
  localparam int         TMASK_UGT    = 4;
  localparam logic [31:0] MQ_RST      = 32'h0000_0000;
  localparam logic [31:0] DEC_RST     = 32'hFFFF_FFFF;
endpackage

// File: hdl/fpx_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module fpx_regfile
  import fpx_pkg::*;
(
  input  wire logic              sys_clk, // core clock
  input  wire logic [GIDX_W-1:0] ra_a,    // read address a
  input  wire logic [GIDX_W-1:0] ra_b,    // read address b
  input  wire logic [GIDX_W-1:0] ra_c,    // read address c
  output logic      [XLEN-1:0]   rd_a_q,  // read data a
  output logic      [XLEN-1:0]   rd_b_q,  // read data b
  output logic      [XLEN-1:0]   rd_c_q,  // read data c
  input  wire logic              we,      // write enable
  input  wire logic [GIDX_W-1:0] wa,      // write address
  input  wire logic [XLEN-1:0]   wd       // write data
);
  logic [XLEN-1:0] mem [GPR_NUM];

  // write-first read so a just-written value is seen
  function automatic logic [XLEN-1:0] rd(input logic [GIDX_W-1:0] a);
    rd = (we && wa == a) ? wd : mem[a];
  endfunction

  // ------------------------------------------------------------------
  // storage and registered reads
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (we)
    begin
      mem[wa] <= wd;
    end
    rd_a_q <= rd(ra_a);
    rd_b_q <= rd(ra_b);
    rd_c_q <= rd(ra_c);
  end
endmodule // fpx_regfile
`default_nettype wire

// File: hdl/fpx_unit.sv
// Summary of operation
// RULE_01: mask bits: slt, sgt, eq, ult, ugt
// RULE_02: trap when masked conditions are nonzero
// RULE_03: compare source with register or sign-extended immediate
// RULE_04: thirty-two 32-bit general registers
// RULE_05: logical operations act bit by bit
// RULE_06: insert rotated bits where mask is one
// RULE_07: rotated value ANDed with mask, written whole
// RULE_08: right rotate n equals left rotate 32-n
// RULE_09: shifts write under a generated mask
// RULE_10: legacy shifts use and update multiply-quotient
// RULE_11: moves special to general and special
// RULE_12: 10-bit number halves swapped; legacy 5-bit
// RULE_13: privilege bit: decrementer 22 versus 6
// RULE_14: decrementer read privileged only in newer mode
// RULE_15: privileged access from user raises exception
`timescale 1ns/1ps
`default_nettype none
module fpx_unit
  import fpx_pkg::*;
(
  input  wire logic              sys_clk,     // 40 MHz core clock
  input  wire logic              sys_rst,     // sync reset, high
  input  wire logic              op_valid,    // operation request
  output logic                   op_ready_q,  // unit can take op
  input  wire logic [3:0]        op_code,     // operation code
  input  wire logic [GIDX_W-1:0] first_source_reg,  // source a
  input  wire logic [GIDX_W-1:0] second_source_reg, // source b
  input  wire logic [GIDX_W-1:0] target_reg,  // target index
  input  wire logic [15:0]       op_imm,      // immediate / fields
  input  wire logic [4:0]        trap_condition_mask, // trap mask
  input  wire logic [SPRF_W-1:0] spr_field,   // source number field
  input  wire logic [SPRF_W-1:0] spr_dst_field, // dest number field
  input  wire logic              legacy_mode, // older variant
  input  wire logic              priv_state,  // supervisor state
  input  wire logic              gpr_load,    // direct register load
  input  wire logic [XLEN-1:0]   gpr_load_data, // load value
  output logic                   done_q,      // op completed pulse
  output logic [XLEN-1:0]        result_q,    // result value
  output logic                   trap_q,      // trap handler call
  output logic                   prog_exc_q,  // program exception
  output logic [XLEN-1:0]        multiply_quotient_reg, // mq view
  output logic [XLEN-1:0]        decrementer_register   // dec view
);
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] rotl(input logic [31:0] v,
                                       input logic [4:0] n);
    rotl = (v << n) | (v >> (6'd32 - {1'b0, n}));
  endfunction

  // mask from begin to end, bit 0 is the msb, wraps around
  function automatic logic [31:0] gen_mask(input logic [4:0] mb,
                                           input logic [4:0] me);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 32; i++)
    begin
      if ((mb <= me) ? (i >= mb && i <= me) : (i >= mb || i <= me))
        m[31-i] = 1'b1;
    end
    gen_mask = m;
  endfunction

  // field halves swapped; legacy keeps only five bits
  function automatic logic [9:0] spr_num(input logic [9:0] f,
                                         input logic leg);
    spr_num = leg ? {5'b0_0000, f[4:0]} : {f[4:0], f[9:5]}; // [RULE_12]
  endfunction

  // ------------------------------------------------------------------
  // issue stage and register file
  // ------------------------------------------------------------------
  logic            ex_q, ex_d;
  logic [3:0]      opc_q, opc_d;
  logic [4:0]      tgt_q, tgt_d, tmask_q, tmask_d;
  logic [15:0]     imm_q, imm_d;
  logic [9:0]      sprs_q, sprs_d, sprd_q, sprd_d;
  logic            leg_q, leg_d, prv_q, prv_d, rdy_d;
  logic [XLEN-1:0] ra_v, rb_v, rt_v;
  logic            gwe;
  logic [4:0]      gwa;
  logic [XLEN-1:0] gwd;
  logic            accept;

  assign accept = op_valid && op_ready_q;

  // thirty-two general registers, three reads  [RULE_04]
  fpx_regfile u_gpr (
    .sys_clk (sys_clk),
    .ra_a    (first_source_reg),
    .ra_b    (second_source_reg),
    .ra_c    (target_reg),
    .rd_a_q  (ra_v),
    .rd_b_q  (rb_v),
    .rd_c_q  (rt_v),
    .we      (gwe),
    .wa      (gwa),
    .wd      (gwd)
  );

  // capture the request fields
  always_comb
  begin
    ex_d    = accept;
    rdy_d   = !accept;
    opc_d   = accept ? op_code : opc_q;
    tgt_d   = accept ? target_reg : tgt_q;
    imm_d   = accept ? op_imm : imm_q;
    tmask_d = accept ? trap_condition_mask : tmask_q;
    sprs_d  = accept ? spr_num(spr_field, legacy_mode) : sprs_q;
    sprd_d  = accept ? spr_num(spr_dst_field, legacy_mode) : sprd_q;
    leg_d   = accept ? legacy_mode : leg_q;
    prv_d   = accept ? priv_state : prv_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ex_q <= 1'b0; op_ready_q <= 1'b1; opc_q <= 4'h0; tgt_q <= 5'h00;
      imm_q <= 16'h0000; tmask_q <= 5'h00; sprs_q <= 10'h000;
      sprd_q <= 10'h000; leg_q <= 1'b0; prv_q <= 1'b0;
    end
    else
    begin
      ex_q <= ex_d; op_ready_q <= rdy_d; opc_q <= opc_d; tgt_q <= tgt_d;
      imm_q <= imm_d; tmask_q <= tmask_d; sprs_q <= sprs_d;
      sprd_q <= sprd_d; leg_q <= leg_d; prv_q <= prv_d;
    end
  end

  // ------------------------------------------------------------------
  // execute
  // ------------------------------------------------------------------
  logic [XLEN-1:0] cmp_b, rot, msk, res, mq_d, dec_d, res_d, spr_rd;
  logic [4:0]      cond, rsh;
  logic [5:0]      shn;
  logic            wr_gpr, trap_d, exc_d, done_d, spr_ok, spr_priv;
  logic            wr_mq, wr_dec;

  // read special register by number, flag unknown numbers
  always_comb
  begin
    spr_ok = 1'b1;
    spr_rd = 32'h0000_0000;
    if (leg_q && sprs_q == SPR_MQ)
      spr_rd = multiply_quotient_reg;
    else if (sprs_q == (leg_q ? SPR_DEC_OLD : SPR_DEC_PRIV)) // [RULE_14]
      spr_rd = decrementer_register;
    else
      spr_ok = 1'b0;
  end

  always_comb
  begin
    cmp_b = (opc_q == OP_TRAP_IMM) ? {{16{imm_q[15]}}, imm_q} : rb_v; // [RULE_03]
    cond[TMASK_SLT] = $signed(ra_v) < $signed(cmp_b); // [RULE_01]
    cond[TMASK_SGT] = $signed(ra_v) > $signed(cmp_b);
    cond[TMASK_EQ]  = ra_v == cmp_b;
    cond[TMASK_ULT] = ra_v < cmp_b;
    cond[TMASK_UGT] = ra_v > cmp_b;
    rsh   = (opc_q == OP_ROTR_MSK) ? 5'(6'd32 - {1'b0, imm_q[4:0]})
                                   : imm_q[4:0]; // [RULE_08]
    shn   = rb_v[5:0];
    rot   = (opc_q >= OP_SHL) ? rotl(ra_v, (opc_q == OP_SHR ||
             opc_q == OP_SHR_MQ) ? 5'(6'd32 - {1'b0, shn[4:0]})
                                 : shn[4:0])
                              : rotl(ra_v, rsh);
    msk   = gen_mask(imm_q[9:5], imm_q[14:10]);
    if (opc_q >= OP_SHL && opc_q <= OP_SHR_MQ)
    begin
      // shift mask from amount, all clear past 31  [RULE_09]
      if (opc_q == OP_SHL || opc_q == OP_SHL_MQ)
        msk = shn[5] ? 32'h0000_0000 : (32'hFFFF_FFFF << shn[4:0]);
      else
        msk = shn[5] ? 32'h0000_0000 : (32'hFFFF_FFFF >> shn[4:0]);
    end
    spr_priv = ((opc_q != OP_MTSPR) && sprs_q[SPR_PRIV_BIT]) ||
               ((opc_q != OP_MFSPR) && sprd_q[SPR_PRIV_BIT]); // [RULE_13]
    res    = 32'h0000_0000;
    wr_gpr = 1'b0;
    wr_mq  = 1'b0;
    wr_dec = 1'b0;
    trap_d = 1'b0;
    exc_d  = 1'b0;
    mq_d   = multiply_quotient_reg;
    case (opc_q)
      OP_TRAP_REG, OP_TRAP_IMM: trap_d = |(cond & tmask_q); // [RULE_02]
      OP_AND:  begin res = ra_v & rb_v;    wr_gpr = 1'b1; end // [RULE_05]
      OP_OR:   begin res = ra_v | rb_v;    wr_gpr = 1'b1; end
      OP_XOR:  begin res = ra_v ^ rb_v;    wr_gpr = 1'b1; end
      OP_NOR:  begin res = ~(ra_v | rb_v); wr_gpr = 1'b1; end
      OP_ROT_INS:
      begin
        res = (rot & msk) | (rt_v & ~msk); // [RULE_06]
        wr_gpr = 1'b1;
      end
      OP_ROT_MASK, OP_ROTR_MSK, OP_SHL, OP_SHR:
      begin
        res = rot & msk; // [RULE_07] [RULE_09]
        wr_gpr = 1'b1;
      end
      OP_SHL_MQ, OP_SHR_MQ:
      begin
        if (!leg_q)
          exc_d = 1'b1;
        else
        begin
          res = (rot & msk) | (multiply_quotient_reg & ~msk); // [RULE_10]
          mq_d = rot;
          wr_mq = 1'b1;
          wr_gpr = 1'b1;
        end
      end
      OP_MFSPR, OP_MTSPR, OP_SPR2SPR:
      begin
        if ((spr_priv && !prv_q) || (opc_q != OP_MTSPR && !spr_ok))
          exc_d = 1'b1; // [RULE_15]
        else if (opc_q == OP_MFSPR)
        begin
          res = spr_rd; // [RULE_11]
          wr_gpr = 1'b1;
        end
        else
        begin
          res = (opc_q == OP_MTSPR) ? ra_v : spr_rd; // [RULE_11]
          if (leg_q && sprd_q == SPR_MQ)
          begin
            mq_d = res;
            wr_mq = 1'b1;
          end
          else if (sprd_q == (leg_q ? SPR_DEC_OLD : SPR_DEC_PRIV))
            wr_dec = 1'b1;
          else
            exc_d = 1'b1;
        end
      end
      default: exc_d = 1'b1;
    endcase
    done_d = ex_q;
    res_d  = ex_q ? res : result_q;
    dec_d  = (ex_q && wr_dec && !exc_d) ? res
                                        : decrementer_register - 32'd1;
    if (!(ex_q && wr_mq && !exc_d))
      mq_d = multiply_quotient_reg;
    gwe = (ex_q && wr_gpr && !exc_d) || gpr_load;
    gwa = (ex_q && wr_gpr) ? tgt_q : target_reg;
    gwd = (ex_q && wr_gpr) ? res : gpr_load_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      done_q <= 1'b0; result_q <= 32'h0000_0000; trap_q <= 1'b0;
      prog_exc_q <= 1'b0; multiply_quotient_reg <= MQ_RST;
      decrementer_register <= DEC_RST;
    end
    else
    begin
      done_q <= done_d; result_q <= res_d;
      trap_q <= ex_q && trap_d; prog_exc_q <= ex_q && exc_d;
      multiply_quotient_reg <= mq_d; decrementer_register <= dec_d;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  property p_trap_eq;
    @(posedge sys_clk) disable iff (sys_rst)
      ex_q && opc_q == OP_TRAP_REG && tmask_q == 5'h04 && ra_v == rb_v
      |=> trap_q;
  endproperty
  a_trap_eq: assert property (p_trap_eq) else $error("eq trap missed"); // [RULE_01]

  property p_no_trap;
    @(posedge sys_clk) disable iff (sys_rst)
      ex_q && tmask_q == 5'h00 |=> !trap_q;
  endproperty
  a_no_trap: assert property (p_no_trap) else $error("spurious trap"); // [RULE_02]

  property p_imm_sext;
    @(posedge sys_clk) disable iff (sys_rst)
      ex_q && opc_q == OP_TRAP_IMM && imm_q == 16'hFFFF
      && ra_v == 32'hFFFF_FFFF && tmask_q == 5'h04 |=> trap_q;
  endproperty
  a_imm_sext: assert property (p_imm_sext) else $error("imm not sext"); // [RULE_03]

  property p_and;
    @(posedge sys_clk) disable iff (sys_rst)
      ex_q && opc_q == OP_AND |=> result_q == ($past(ra_v) & $past(rb_v));
  endproperty
  a_and: assert property (p_and) else $error("and wrong"); // [RULE_05]

  property p_ins_keep;
    @(posedge sys_clk) disable iff (sys_rst)
      ex_q && opc_q == OP_ROT_INS |=>
        ((result_q ^ $past(rt_v)) & ~$past(msk)) == 32'h0000_0000;
  endproperty
  a_ins_keep: assert property (p_ins_keep) else $error("insert lost"); // [RULE_06]

  property p_rotr;
    @(posedge sys_clk) disable iff (sys_rst)
      ex_q && opc_q == OP_ROTR_MSK && imm_q[14:5] == 10'h3E0
      && imm_q[4:0] == 5'd8 |=>
        result_q == {$past(ra_v[7:0]), $past(ra_v[31:8])};
  endproperty
  a_rotr: assert property (p_rotr) else $error("right rotate wrong"); // [RULE_08]

  property p_priv_exc;
    @(posedge sys_clk) disable iff (sys_rst)
      accept && op_code == OP_MFSPR && !priv_state && !legacy_mode
      && spr_field == 10'h2C0 ##1 1'b1 |=> prog_exc_q && done_q;
  endproperty
  a_priv_exc: assert property (p_priv_exc) else $error("no priv exc"); // [RULE_15]

  property p_legacy_dec;
    @(posedge sys_clk) disable iff (sys_rst)
      accept && op_code == OP_MFSPR && legacy_mode && !priv_state
      && spr_field == 10'h006 ##1 1'b1 |=> !prog_exc_q;
  endproperty
  a_legacy_dec: assert property (p_legacy_dec) else $error("dec refused"); // [RULE_14]

  property p_mq_upd;
    @(posedge sys_clk) disable iff (sys_rst)
      ex_q && leg_q && opc_q == OP_SHL_MQ |=>
        multiply_quotient_reg == $past(rot);
  endproperty
  a_mq_upd: assert property (p_mq_upd) else $error("mq not updated"); // [RULE_10]

  c_trap: cover property (@(posedge sys_clk) trap_q);
  c_exc:  cover property (@(posedge sys_clk) prog_exc_q);
  c_mq:   cover property (@(posedge sys_clk)
            ex_q && leg_q && opc_q == OP_SHR_MQ);
endmodule // fpx_unit
`default_nettype wire

// File: verif/fpx_issue_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// issue side of the decoder: holds each request until the unit takes it
// ----------------------------------------------------------------------
module fpx_issue_model
(
  input  wire logic sys_clk,    // core clock
  input  wire logic sys_rst,    // sync reset, high
  input  wire logic go,         // issue one request
  input  wire logic op_ready_q, // unit can take op
  output logic      op_valid    // request to unit
);
  logic go_seen; // go sampled on the rising edge
  logic taken;   // request taken on the last edge

  initial op_valid = 1'b0;

  // sample bench request and the take on the rising edge
  always @(posedge sys_clk)
  begin
    go_seen <= go & ~sys_rst;
    taken   <= op_valid & op_ready_q & ~sys_rst;
  end

  // change the request just after an edge; hold it until taken
  always @(negedge sys_clk)
  begin
    if (sys_rst)
      op_valid <= 1'b0;
    else if (go_seen)
      op_valid <= 1'b1;
    else if (taken)
      op_valid <= 1'b0;
  end
endmodule // fpx_issue_model
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fpx_pkg::*;
  logic        sys_clk, sys_rst, go, op_valid, op_ready_q, done_q;
  logic        trap_q, prog_exc_q, legacy_mode, priv_state, gload, ex;
  logic [3:0]  op;
  logic [4:0]  sa, sb, st, tm, x, y, z;
  logic [15:0] im;
  logic [9:0]  srf, sdf, f;
  logic [31:0] ldv, result_q, quo_view, decr_view, seed, a, b, e, m, r;
  logic [31:0] gv [32];
  logic [12:0] tbl [5];
  int          error_cnt, n_tests, cyc;

  fpx_unit i_fpx_unit (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .op_valid(op_valid), .op_ready_q(op_ready_q), .op_code(op),
    .first_source_reg(sa), .second_source_reg(sb), .target_reg(st),
    .op_imm(im), .trap_condition_mask(tm), .spr_field(srf),
    .spr_dst_field(sdf), .legacy_mode(legacy_mode),
    .priv_state(priv_state), .gpr_load(gload), .gpr_load_data(ldv),
    .done_q(done_q), .result_q(result_q), .trap_q(trap_q),
    .prog_exc_q(prog_exc_q), .multiply_quotient_reg(quo_view),
    .decrementer_register(decr_view));
  fpx_issue_model i_fpx_issue_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .go(go), .op_ready_q(op_ready_q), .op_valid(op_valid));

  // ---------------------------------------------------------------------
  // expectation helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [31:0] rotl(input logic [31:0] v,
                                       input logic [4:0] n);
    logic [63:0] t;
    t = {v, v} << n;
    return t[63:32];
  endfunction
  // mask from begin to end, bit 0 is the msb, wraps when begin > end
  function automatic logic [31:0] mkmask(input logic [4:0] mb,
                                         input logic [4:0] me);
    logic [31:0] k;
    for (int i = 0; i < 32; i++)
      k[31-i] = (mb <= me) ? (i >= mb && i <= me) : (i >= mb || i <= me);
    return k;
  endfunction
  function automatic logic trap_exp(input logic [31:0] p, input logic [31:0] q,
                                    input logic [4:0] k);
    logic [4:0] c;
    c = {p > q, p < q, p == q, $signed(p) > $signed(q), $signed(p) < $signed(q)};
    return |(c & k);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic gload_t(input logic [4:0] i, input logic [31:0] v);
    @(negedge sys_clk) gload = 1'b1;
    st = i;
    ldv = v;
    @(negedge sys_clk) gload = 1'b0;
  endtask
  // one operation: fields held until done, bounded wait
  task automatic run(input logic [3:0] o, input logic [4:0] p, q, t,
                     input logic [15:0] i = 16'h0000,
                     input logic [4:0] k = 5'h00,
                     input logic [9:0] s = 10'h000, d = 10'h000);
    int w;
    @(negedge sys_clk);
    {op, sa, sb, st, im, tm, srf, sdf} = {o, p, q, t, i, k, s, d};
    go <= 1'b1;
    @(negedge sys_clk) go <= 1'b0;
    for (w = 0; w < 12 && done_q !== 1'b1; w++)
      @(negedge sys_clk);
    chk(32'(done_q), 32'h0000_0001);
  endtask
  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // clock and hang guard
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      final_report;
    end
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial
  begin
    {sys_rst, go, gload, legacy_mode, priv_state} = 5'b10001;
    {op, sa, sb, st, im, tm, srf, sdf, ldv} = '0;
    seed = 32'h1818_e8ca;
    tbl = '{13'h06C0, 13'h0AC0, 13'h1006, 13'h0CC0, 13'h1C16};
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk({quo_view[31:1], op_ready_q}, MQ_RST | 1);
    e = decr_view;
    @(negedge sys_clk) chk(decr_view, e - 1);
    chk(e, DEC_RST);
    for (int i = 0; i < 32; i++)
    begin
      seed = xs(seed);
      gv[i] = seed;
      gload_t(i[4:0], seed);
    end
    for (int i = 1; i < 32; i += 6)
    begin
      run(OP_OR, i[4:0], i[4:0], 5'd0);
      chk(result_q, gv[i]);
      gv[0] = gv[i];
    end
    $display("test registers done");
    // random logical ops, dependent targets reused back to back
    repeat (24)
    begin
      seed = xs(seed);
      {z, y, x} = seed[14:0];
      op = OP_AND + {2'b00, seed[16:15]};
      a = gv[x];
      b = gv[y];
      case (op)
        OP_AND: e = a & b;
        OP_OR:  e = a | b;
        OP_XOR: e = a ^ b;
        default: e = ~(a | b);
      endcase
      run(op, x, y, z);
      chk(result_q, e);
      gv[z] = e;
    end
    $display("test logical done");
    // traps: equal corner first, then random reg and imm forms
    gload_t(5'd1, 32'hFFFF_FFFF);
    gv[1] = 32'hFFFF_FFFF;
    run(OP_TRAP_IMM, 5'd1, 5'd1, 5'd0, 16'hFFFF, 5'h04);
    chk({result_q[31:1], trap_q}, 32'h0000_0001);
    run(OP_TRAP_IMM, 5'd1, 5'd1, 5'd0, 16'hFFFF, 5'h1B);
    chk(32'(trap_q), 32'h0000_0000);
    repeat (40)
    begin
      seed = xs(seed);
      x = seed[4:0];
      y = seed[26] ? x : seed[9:5];
      im = seed[31:16];
      b = seed[15] ? {{16{im[15]}}, im} : gv[y];
      run(seed[15] ? OP_TRAP_IMM : OP_TRAP_REG, x, y, 5'd0, im, seed[14:10]);
      e = {31'd0, trap_exp(gv[x], b, seed[14:10])};
      chk({result_q[31:1], trap_q}, e);
    end
    $display("test trap done");
    // rotates: full-mask right rotate by 8 first, then random
    e = rotl(gv[3], 5'd24);
    run(OP_ROTR_MSK, 5'd3, 5'd3, 5'd4, 16'h7C08);
    chk(result_q, e);
    gv[4] = e;
    repeat (30)
    begin
      seed = xs(seed);
      {z, x} = seed[9:0];
      im = {1'b0, seed[24:10]};
      m = mkmask(im[9:5], im[14:10]);
      r = rotl(gv[x], im[4:0]);
      case (seed[26:25])
        2'd0: {op, e} = {OP_ROT_MASK, r & m};
        2'd1: {op, e} = {OP_ROT_INS, (r & m) | (gv[z] & ~m)};
        default: {op, e} = {OP_ROTR_MSK, rotl(gv[x], 5'(6'd32 - im[4:0])) & m};
      endcase
      run(op, x, x, z, im);
      chk(result_q, e);
      gv[z] = e;
    end
    $display("test rotate done");
    repeat (16)
    begin
      seed = xs(seed);
      {z, y, x} = seed[14:0];
      e = seed[21] ? gv[x] >> gv[y][5:0] : gv[x] << gv[y][5:0];
      run(seed[21] ? OP_SHR : OP_SHL, x, y, z);
      chk(result_q, e);
      gv[z] = e;
    end
    $display("test shift done");
    // quotient register only in the older variant
    run(OP_SHL_MQ, 5'd1, 5'd2, 5'd3);
    chk({quo_view[31:1], prog_exc_q}, 32'h0000_0001);
    legacy_mode = 1'b1;
    run(OP_MTSPR, 5'd5, 5'd5, 5'd0);
    chk(quo_view, gv[5]);
    run(OP_MFSPR, 5'd0, 5'd0, 5'd6);
    chk(result_q, gv[5]);
    gload_t(5'd8, 32'h0000_0004);
    r = rotl(gv[7], 5'd4);
    run(OP_SHL_MQ, 5'd7, 5'd8, 5'd9);
    chk(result_q, (r & 32'hFFFF_FFF0) | (gv[5] & 32'h0000_000F));
    chk(quo_view, r);
    $display("test quotient done");
    // decrementer reads under each mode and privilege state
    for (int i = 0; i < 5; i++)
    begin
      {legacy_mode, priv_state, ex, f} = tbl[i];
      run(OP_MFSPR, 5'd0, 5'd0, 5'd0, 16'h0000, 5'h00, f);
      chk(32'(prog_exc_q), 32'(ex));
      e = result_q - decr_view;
      chk(ex ? result_q : 32'(e + 8 < 16), 32'(!ex));
    end
    {legacy_mode, priv_state} = 2'b11;
    run(OP_SPR2SPR, 5'd0, 5'd0, 5'd0, 16'h0000, 5'h00, 10'h006, 10'h000);
    e = quo_view - decr_view;
    chk({prog_exc_q, 31'(e + 8 < 16)}, 32'h0000_0001);
    $display("test special done");
    final_report;
  end
endmodule // tb_top
`default_nettype wire
